/* File: inc/fade_pkg.sv */
`default_nettype none
package fade_pkg;
   localparam logic [7:0] FADE_RATES_ADDR = 8'h08;
   localparam logic [7:0] FADE_RATES_RESET = 8'h00;
   localparam int FALL_MSB = 7;
   localparam int FALL_LSB = 4;
   localparam int RISE_MSB = 3;
   localparam int RISE_LSB = 0;
   localparam int LEVEL_W = 7;
   localparam logic [6:0] LEVEL_FULL = 7'h7f;
   localparam int CLK_HZ = 20000000;
   localparam int FAST_FADE_MS = 100;
   // one tick is the time per level step of a 0.1 s full-scale ramp, rounded down
   localparam int TICK_CYCLES = FAST_FADE_MS * (CLK_HZ / 1000) / 127;
   localparam int TENTHS_W = 6;

   typedef enum logic [1:0] {HOLD, FALL, RISE} fade_state_t;

   // full-scale ramp time in tenths of a second, i.e. ticks per level step
   function automatic logic [5:0] ramp_tenths(input logic [3:0] code);
      logic [5:0] c;
      c = {2'h0, code};
      if (code == 4'h0) begin
         ramp_tenths = 6'h01;
      end else if (code <= 4'ha) begin
         ramp_tenths = 6'(c * 6'h03);
      end else begin
         ramp_tenths = 6'(6'h23 + (c - 6'h0b) * 6'h05);
      end
   endfunction
endpackage
`default_nettype wire

/* File: logic/tick_divider.sv */
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
   parameter int DIV = 16
) (
   input wire logic clk,   // system clock
   input wire logic arst_n, // async reset, active low
   input wire logic run,   // counts while high, clears when low
   output logic tick       // one-cycle pulse every DIV cycles
);
   logic [31:0] count;
   wire logic at_end = (count == 32'(DIV - 1));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= 32'h0;
      end else if (!run || at_end) begin
         count <= 32'h0;
      end else begin
         count <= count + 32'h1;
      end
   end

   assign tick = run && at_end;
endmodule
`default_nettype wire

/* File: logic/backlight_fade_rate_control.sv */
`timescale 1ns/10ps
`default_nettype none
module backlight_fade_rate_control #(
   parameter int TICK_CYCLES = fade_pkg::TICK_CYCLES
) (
   input wire logic CLK_SYS,            // system clock, 20 MHz
   input wire logic ARST_N,             // async reset, active low
   input wire logic CFG_WE,             // configuration write strobe
   input wire logic CFG_RE,             // configuration read strobe
   input wire logic [7:0] CFG_ADDR,     // register address
   input wire logic [7:0] CFG_WDATA,    // write data
   output logic [7:0] CFG_RDATA,        // read data, registered
   input wire logic BL_ON,              // backlight switched on
   input wire logic DIM_EXPIRED,        // dim delay has run out
   input wire logic [6:0] BL_MAX_LEVEL, // maximum current code
   input wire logic [6:0] BL_DIM_LEVEL, // dim current code
   output logic [6:0] BL_LEVEL,         // present current code
   output logic BL_FADING               // ramp in progress
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] fade_rates;
   logic [5:0] tick_cnt;
   logic [6:0] level;
   fade_pkg::fade_state_t state;

   wire logic rates_hit = (CFG_ADDR == fade_pkg::FADE_RATES_ADDR);
   wire logic rates_write = CFG_WE && rates_hit;
   wire logic [3:0] fall_ramp_select = fade_rates[fade_pkg::FALL_MSB:fade_pkg::FALL_LSB];
   wire logic [3:0] rise_ramp_select = fade_rates[fade_pkg::RISE_MSB:fade_pkg::RISE_LSB];
   wire logic [5:0] fall_period = fade_pkg::ramp_tenths(fall_ramp_select);
   wire logic [5:0] rise_period = fade_pkg::ramp_tenths(rise_ramp_select);

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         fade_rates <= fade_pkg::FADE_RATES_RESET;
      end else if (rates_write) begin
         fade_rates <= CFG_WDATA;
      end
   end

   // unmapped addresses read as zero
   wire logic [7:0] next_rdata = rates_hit ? fade_rates : 8'h00;
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         CFG_RDATA <= 8'h00;
      end else if (CFG_RE) begin
         CFG_RDATA <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // target: off when switched off, dim once the dim delay expires, else maximum
   wire logic [6:0] target = !BL_ON ? 7'h00 : (DIM_EXPIRED ? BL_DIM_LEVEL : BL_MAX_LEVEL);
   wire logic go_down = (level > target);
   wire logic go_up = (level < target);
   wire fade_pkg::fade_state_t next_state =
      fade_pkg::fade_state_t'(go_down ? fade_pkg::FALL : (go_up ? fade_pkg::RISE : fade_pkg::HOLD));
   wire logic [5:0] period = (state == fade_pkg::FALL) ? fall_period : rise_period;
   // a direction change restarts the step timer so a stale count never leaks into the new ramp
   wire logic moving = (state != fade_pkg::HOLD) && (state == next_state);
   wire logic tick;
   wire logic period_done = tick && (tick_cnt == 6'(period - 6'h01));
   // one level code per period: a shorter swing needs fewer steps, hence less time
   wire logic step = moving && period_done;

   tick_divider #(
      .DIV(TICK_CYCLES)
   ) u_tick (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .run(moving),
      .tick(tick)
   );

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= fade_pkg::HOLD;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         tick_cnt <= 6'h00;
      end else if (!moving || period_done) begin
         tick_cnt <= 6'h00;
      end else if (tick) begin
         tick_cnt <= tick_cnt + 6'h01;
      end
   end

   // code zero gives a one-tick period: full scale in 0.1 s rather than a jump
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         level <= 7'h00;
      end else if (step && state == fade_pkg::FALL) begin
         level <= level - 7'h01;
      end else if (step && state == fade_pkg::RISE) begin
         level <= level + 7'h01;
      end
   end

   assign BL_LEVEL = level;
   assign BL_FADING = (state != fade_pkg::HOLD);

   ////////////////////////////////////////////////////////////////////////////////
   // checking aid: cycles since the ramp or its last step began; a rate write while
   // moving spoils only the interval it lands in, which the pace check then skips
   logic [31:0] step_gap;
   logic gap_spoilt;

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         step_gap <= 32'h0;
      end else if (!moving || step) begin
         step_gap <= 32'h0;
      end else begin
         step_gap <= step_gap + 32'h1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         gap_spoilt <= 1'b0;
      end else if (!moving || step) begin
         gap_spoilt <= 1'b0;
      end else if (rates_write) begin
         gap_spoilt <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   level_step_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (level != $past(level)) |-> ((level == $past(level) + 7'h01) || (level == $past(level) - 7'h01)))
      else $error("level moved by more than one code");
   fall_dir_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (level < $past(level)) |-> ($past(target) < $past(level)))
      else $error("level fell below its target");
   rise_dir_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (level > $past(level)) |-> ($past(BL_ON) && $past(target) > $past(level)))
      else $error("level rose without switch on or above target");
   fall_code_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (step && state == fade_pkg::FALL) |-> (tick_cnt == 6'(fade_pkg::ramp_tenths(fade_rates[7:4]) - 6'h01)))
      else $error("fall step not paced by upper nibble");
   fast_fall_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (fade_rates[7:4] == 4'h0 && moving && state == fade_pkg::FALL && tick) |=> (level == $past(level) - 7'h01))
      else $error("fast fall did not step on each tick");
   fast_rise_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (fade_rates[3:0] == 4'h0 && moving && state == fade_pkg::RISE && tick) |=> (level == $past(level) + 7'h01))
      else $error("fast rise did not step on each tick");
   rise_table_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (rise_ramp_select == 4'h3) |-> (rise_period == 6'h09))
      else $error("rise code 3 is not 0.9 s");
   fall_table_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (fall_ramp_select == 4'hf) |-> (fall_period == 6'h37))
      else $error("fall code 15 is not 5.5 s");
   mid_scale_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (rise_ramp_select == fall_ramp_select) |-> (rise_period == fall_period))
      else $error("rise and fall scales differ");
   dim_target_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (BL_ON && DIM_EXPIRED && level > BL_DIM_LEVEL) |=> (state == fade_pkg::FALL || level <= BL_DIM_LEVEL))
      else $error("dim expiry did not start a fall");
   rate_write_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      rates_write |=> (fade_rates == $past(CFG_WDATA)))
      else $error("fade rate write lost");

   // a ramp starts on the cycle after its target moves and ends the cycle after it is met
   start_ramp_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (level != target) |=> (state != fade_pkg::HOLD))
      else $error("level away from target but no ramp started");
   ramp_settle_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (level == target) |=> (state == fade_pkg::HOLD))
      else $error("ramp still running after target reached");
   off_fall_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (!BL_ON && level != 7'h00) |=> (state == fade_pkg::FALL))
      else $error("switch off did not start a fall");
   max_rise_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (BL_ON && !DIM_EXPIRED && level < BL_MAX_LEVEL) |=> (state == fade_pkg::RISE))
      else $error("switch on did not start a rise to maximum");
   dim_rise_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (BL_ON && DIM_EXPIRED && level < BL_DIM_LEVEL) |=> (state == fade_pkg::RISE))
      else $error("level below dim target did not rise");
   hold_still_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (state == fade_pkg::HOLD) |=> (level == $past(level)))
      else $error("level moved while no ramp was running");

   // pace of the steps against the selected code
   rise_code_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (step && state == fade_pkg::RISE) |-> (tick_cnt == 6'(fade_pkg::ramp_tenths(fade_rates[3:0]) - 6'h01)))
      else $error("rise step not paced by lower nibble");
   step_pace_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (step && !gap_spoilt) |-> (step_gap == 32'(TICK_CYCLES) * {26'h0, period} - 32'h1))
      else $error("level step off the selected pace");
   tick_count_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (moving && !gap_spoilt) |-> (tick_cnt < period))
      else $error("tick count ran past its period");
   tick_gate_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      tick |-> moving)
      else $error("tick seen while no ramp was moving");
   step_restart_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (state != next_state) |=> (tick_cnt == 6'h00))
      else $error("direction change kept a stale tick count");

   // register port
   rate_keep_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      !rates_write |=> (fade_rates == $past(fade_rates)))
      else $error("fade rates changed without a write");
   read_back_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (CFG_RE && rates_hit) |=> (CFG_RDATA == $past(fade_rates)))
      else $error("read did not return the fade rates");
   read_hold_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      !CFG_RE |=> (CFG_RDATA == $past(CFG_RDATA)))
      else $error("read data changed without a read");
   read_zero_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      (CFG_RE && !rates_hit) |=> (CFG_RDATA == 8'h00))
      else $error("unmapped read did not return zero");

   // main scenarios a run should reach
   cover_fall_c: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) step && state == fade_pkg::FALL);
   cover_rise_c: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) step && state == fade_pkg::RISE);
   cover_dim_c: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) BL_ON && DIM_EXPIRED && level == BL_DIM_LEVEL);
   cover_off_c: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) !BL_ON && step && state == fade_pkg::FALL);
   cover_fast_c: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) fade_rates[7:4] == 4'h0 && step);
endmodule
`default_nettype wire

/* File: verification/tb_backlight_fade_rate_control.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_backlight_fade_rate_control;
   typedef struct {logic [7:0] rates; logic on; logic dx; logic [6:0] mx; logic [6:0] dm; logic [6:0] tgt;} row_t;
   localparam int TC = 2;
   logic CLK_SYS = 1'b0, ARST_N = 1'b0, CFG_WE = 1'b0, CFG_RE = 1'b0, BL_ON = 1'b0, DIM_EXPIRED = 1'b0;
   logic [7:0] CFG_ADDR = 8'h00, CFG_WDATA = 8'h00, CFG_RDATA, rd;
   logic [6:0] BL_MAX_LEVEL = 7'h00, BL_DIM_LEVEL = 7'h00, BL_LEVEL, lvl;
   logic BL_FADING;
   int err_count = 0, samples_checked = 0, n, p;
   row_t rows [10] = '{'{8'h00, 1'h1, 1'h0, 7'h03, 7'h00, 7'h03}, '{8'h01, 1'h1, 1'h0, 7'h05, 7'h00, 7'h05},
      '{8'hb0, 1'h1, 1'h1, 7'h05, 7'h02, 7'h02}, '{8'h0f, 1'h1, 1'h0, 7'h03, 7'h02, 7'h03},
      '{8'h50, 1'h0, 1'h0, 7'h03, 7'h02, 7'h00}, '{8'h04, 1'h1, 1'h0, 7'h02, 7'h00, 7'h02},
      '{8'hf0, 1'h1, 1'h1, 7'h02, 7'h01, 7'h01}, '{8'ha0, 1'h0, 1'h0, 7'h02, 7'h01, 7'h00},
      '{8'h03, 1'h1, 1'h0, 7'h02, 7'h01, 7'h02}, '{8'h0c, 1'h0, 1'h0, 7'h02, 7'h01, 7'h00}};
   backlight_fade_rate_control #(.TICK_CYCLES(TC)) dut (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .CFG_WE(CFG_WE),
      .CFG_RE(CFG_RE), .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .BL_ON(BL_ON),
      .DIM_EXPIRED(DIM_EXPIRED), .BL_MAX_LEVEL(BL_MAX_LEVEL), .BL_DIM_LEVEL(BL_DIM_LEVEL), .BL_LEVEL(BL_LEVEL),
      .BL_FADING(BL_FADING));
   initial begin
      forever #25 CLK_SYS = ~CLK_SYS;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic fail(input logic [31:0] g, input logic [31:0] e);
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
   endtask
   task automatic chk_data(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) fail(32'(g), 32'(e));
   endtask
   task automatic chk_level(input logic [6:0] g, input logic [6:0] e);
      samples_checked++;
      if (g !== e) fail(32'(g), 32'(e));
   endtask
   task automatic chk_flag(input logic g, input logic e);
      samples_checked++;
      if (g !== e) fail(32'(g), 32'(e));
   endtask
   task automatic chk_count(input int g, input int e);
      samples_checked++;
      if (g != e) fail(32'(g), 32'(e));
   endtask
   task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge CLK_SYS) {CFG_WE, CFG_ADDR, CFG_WDATA} = {1'b1, a, d};
      @(negedge CLK_SYS) CFG_WE = 1'b0;
   endtask
   // sampled one full edge after the strobe edge so either read latency reading holds
   task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge CLK_SYS) {CFG_RE, CFG_ADDR} = {1'b1, a};
      @(negedge CLK_SYS) CFG_RE = 1'b0;
      @(posedge CLK_SYS) #1 d = CFG_RDATA;
   endtask
   function automatic int period(input logic [3:0] c);
      period = (c == 4'h0) ? 1 : (c <= 4'ha) ? 3 * c : 35 + 5 * (c - 11);
   endfunction
   task automatic end_sim();
      if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #1500000;
      err_count++;
      end_sim();
   end
   initial begin
      repeat (10) @(negedge CLK_SYS);
      chk_data(CFG_RDATA, 8'h00);
      chk_level(BL_LEVEL, 7'h00);
      chk_flag(BL_FADING, 1'b0);
      ARST_N = 1'b1;
      cfg_read(8'h08, rd);
      chk_data(rd, fade_pkg::FADE_RATES_RESET);
      lvl = 7'h00;
      foreach (rows[i]) begin
         cfg_write(8'h08, rows[i].rates);
         cfg_read(8'h08, rd);
         chk_data(rd, rows[i].rates);
         // pick the nibble by direction; the step count is the code distance
         p = TC * period(rows[i].tgt > lvl ? rows[i].rates[3:0] : rows[i].rates[7:4]);
         p = 1 + p * ((rows[i].tgt > lvl) ? (rows[i].tgt - lvl) : (lvl - rows[i].tgt));
         @(negedge CLK_SYS) {BL_ON, DIM_EXPIRED, BL_MAX_LEVEL, BL_DIM_LEVEL} =
            {rows[i].on, rows[i].dx, rows[i].mx, rows[i].dm};
         n = 0;
         while (n < 2000 && BL_LEVEL !== rows[i].tgt) begin
            @(posedge CLK_SYS) #1 n++;
            if (n == 2) chk_flag(BL_FADING, 1'b1);
         end
         chk_count(n, p);
         chk_level(BL_LEVEL, rows[i].tgt);
         @(posedge CLK_SYS) #1 chk_flag(BL_FADING, 1'b0);
         lvl = rows[i].tgt;
      end
      cfg_write(8'h07, 8'h5a);
      cfg_read(8'h08, rd);
      chk_data(rd, 8'h0c);
      cfg_read(8'h07, rd);
      chk_data(rd, 8'h00);
      cfg_write(8'h08, 8'h0f);
      @(negedge CLK_SYS) {BL_ON, DIM_EXPIRED, BL_MAX_LEVEL} = {1'b1, 1'b0, 7'h7f};
      repeat (250) @(negedge CLK_SYS);
      chk_level(BL_LEVEL, 7'h02);
      // reset in mid-ramp must drop level, flag and register at once
      ARST_N = 1'b0;
      #1 chk_level(BL_LEVEL, 7'h00);
      chk_flag(BL_FADING, 1'b0);
      repeat (2) @(negedge CLK_SYS);
      {ARST_N, BL_ON} = 2'b10;
      cfg_read(8'h08, rd);
      chk_data(rd, 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
